// File: design/bdp_desc_regs.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module bdp_desc_regs
	import bdp_pkg::*;
(
	input  wire logic                  mclk,          // System clock
	input  wire logic                  sys_rst,       // Async reset
	input  wire logic [BDP_ADDR_W-1:0] s_axi_awaddr,  // Write address
	input  wire logic [2:0]            s_axi_awprot,  // Unused protection
	input  wire logic                  s_axi_awvalid, // Write address valid
	output logic                       s_axi_awready, // Write address ready
	input  wire logic [31:0]           s_axi_wdata,   // Write data
	input  wire logic [3:0]            s_axi_wstrb,   // Byte enables
	input  wire logic                  s_axi_wvalid,  // Write data valid
	output logic                       s_axi_wready,  // Write data ready
	output logic [1:0]                 s_axi_bresp,   // Write response
	output logic                       s_axi_bvalid,  // Write response valid
	input  wire logic                  s_axi_bready,  // Write response ready
	input  wire logic [BDP_ADDR_W-1:0] s_axi_araddr,  // Read address
	input  wire logic [2:0]            s_axi_arprot,  // Unused protection
	input  wire logic                  s_axi_arvalid, // Read address valid
	output logic                       s_axi_arready, // Read address ready
	output logic [31:0]                s_axi_rdata,   // Read data
	output logic [1:0]                 s_axi_rresp,   // Read response
	output logic                       s_axi_rvalid,  // Read data valid
	input  wire logic                  s_axi_rready,  // Read data ready
	input  wire bdp_pkg::bdp_tx_evt_t  txEvt,         // Transmit events
	input  wire bdp_pkg::bdp_rx_evt_t  rxEvt,         // Receive events
	output bdp_pkg::bdp_ptr_t          descPtr,       // Descriptor pointers
	output logic                       txRun,         // Transmit DMA enabled
	output logic                       rxRun,         // Receive DMA enabled
	output logic                       rxStoreEnable, // Next byte may be stored
	output logic                       rxOversizeErr, // Oversize error pulse
	output logic                       irq            // Level interrupt
);
	import bdp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave and register decode

	logic                  wrEn;
	logic [BDP_ADDR_W-1:0] wrAddr;
	logic [31:0]           wrData;
	logic [3:0]            wrStrb;
	logic                  wrOk;
	logic [31:0]           rdData;
	logic                  rdOk;
	logic [31:0]           status;
	logic                  irqInt;

	bdp_axil_slave uSlave (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wrEn          (wrEn),
		.wrAddr        (wrAddr),
		.wrData        (wrData),
		.wrStrb        (wrStrb),
		.wrOk          (wrOk),
		.rdData        (rdData),
		.rdOk          (rdOk)
	);

	// Word address match, low two bits ignored
	function automatic logic hit(input logic [BDP_ADDR_W-1:0] a, input logic [15:0] off);
		hit = (a[BDP_ADDR_W-1:2] == off[BDP_ADDR_W-1:2]);
	endfunction

	// Byte lane merge of a write into a word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		end
		merge = r;
	endfunction

	logic wrCtrl;
	logic wrTx;
	logic wrRx;
	logic wrSize;
	logic wrClr;
	logic wrEnReg;

	// Write decode by word address; status takes writes and ignores them
	always_comb
	begin
		wrCtrl  = 1'b0;
		wrTx    = 1'b0;
		wrRx    = 1'b0;
		wrSize  = 1'b0;
		wrClr   = 1'b0;
		wrEnReg = 1'b0;
		wrOk    = 1'b0;
		case (wrAddr[BDP_ADDR_W-1:2])
			OFF_CTRL[BDP_ADDR_W-1:2]:
			begin
				wrCtrl = wrEn;
				wrOk   = 1'b1;
			end
			OFF_TX_PTR[BDP_ADDR_W-1:2]:
			begin
				wrTx = wrEn;
				wrOk = 1'b1;
			end
			OFF_RX_PTR[BDP_ADDR_W-1:2]:
			begin
				wrRx = wrEn;
				wrOk = 1'b1;
			end
			OFF_RX_SIZE[BDP_ADDR_W-1:2]:
			begin
				wrSize = wrEn;
				wrOk   = 1'b1;
			end
			OFF_IRQ_CLR[BDP_ADDR_W-1:2]:
			begin
				wrClr = wrEn;
				wrOk  = 1'b1;
			end
			OFF_IRQ_EN[BDP_ADDR_W-1:2]:
			begin
				wrEnReg = wrEn;
				wrOk    = 1'b1;
			end
			OFF_STATUS[BDP_ADDR_W-1:2]:
				wrOk = 1'b1;
			default:
				wrOk = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers and descriptor pointers

	logic [1:0]  ctrl_r, ctrl_nxt;
	logic [31:0] txPtr_r, txPtr_nxt;
	logic [31:0] rxPtr_r, rxPtr_nxt;
	logic [15:0] rxMax_r, rxMax_nxt;
	logic [31:0] irqEn_r, irqEn_nxt;
	logic [31:0] sizeWord;
	logic [31:0] ctrlWord;

	assign sizeWord = merge({CAP_RST, rxMax_r}, wrData, wrStrb);
	assign ctrlWord = merge({30'h00000000, ctrl_r}, wrData, wrStrb);

	// Next values; a frame advance beats a software write
	always_comb
	begin
		ctrl_nxt  = ctrl_r;
		txPtr_nxt = txPtr_r;
		rxPtr_nxt = rxPtr_r;
		rxMax_nxt = rxMax_r;
		irqEn_nxt = irqEn_r;
		if (wrCtrl)
			ctrl_nxt = ctrlWord[CTL_RX_RUN:CTL_TX_RUN];
		if (wrTx)
			txPtr_nxt = merge(txPtr_r, wrData, wrStrb);
		if (wrRx)
			rxPtr_nxt = merge(rxPtr_r, wrData, wrStrb);
		if (wrSize)
			rxMax_nxt = sizeWord[MAX_LSB +: 16];
		if (wrEnReg)
			irqEn_nxt = merge(irqEn_r, wrData, wrStrb) & ST_IMPL;
		if (ctrl_r[CTL_TX_RUN] & txEvt.done)
			txPtr_nxt[DESC_W-1:0] = txEvt.nextDesc;
		if (ctrl_r[CTL_RX_RUN] & rxEvt.stored)
			rxPtr_nxt[DESC_W-1:0] = rxEvt.nextDesc;
	end

	// Register storage
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_r  <= CTRL_RST;
			txPtr_r <= PTR_RST;
			rxPtr_r <= PTR_RST;
			rxMax_r <= MAX_RST;
			irqEn_r <= IRQ_EN_RST;
		end
		else
		begin
			ctrl_r  <= ctrl_nxt;
			txPtr_r <= txPtr_nxt;
			rxPtr_r <= rxPtr_nxt;
			rxMax_r <= rxMax_nxt;
			irqEn_r <= irqEn_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive length tracking, early capture and size limit

	logic [15:0] byteCnt_r, byteCnt_nxt;
	logic [15:0] rxCap_r, rxCap_nxt;
	logic        storeEn_r, storeEn_nxt;
	logic        overSeen_r, overSeen_nxt;
	logic        overErr_r, overErr_nxt;
	logic [15:0] cntBase;
	logic [15:0] cntInc;

	// Count restarts on the first byte of a frame
	assign cntBase = rxEvt.start ? 16'h0000 : byteCnt_r;
	assign cntInc  = (cntBase == CNT_MAX) ? cntBase : cntBase + 16'h0001;

	// Byte count, store gate and oversize detection
	always_comb
	begin
		byteCnt_nxt  = cntBase;
		overSeen_nxt = rxEvt.start ? 1'b0 : overSeen_r;
		overErr_nxt  = 1'b0;
		rxCap_nxt    = rxCap_r;
		if (rxEvt.byteValid)
			byteCnt_nxt = cntInc;
		storeEn_nxt = (byteCnt_nxt < rxMax_r);
		if (rxEvt.byteValid & (cntInc > rxMax_r) & ~overSeen_nxt)
		begin
			overSeen_nxt = 1'b1;
			overErr_nxt  = 1'b1;
		end
		if (rxEvt.lenTypeValid)
			rxCap_nxt = rxEvt.lenType;
	end

	// Length tracking registers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			byteCnt_r  <= 16'h0000;
			rxCap_r    <= CAP_RST;
			storeEn_r  <= 1'b0;
			overSeen_r <= 1'b0;
			overErr_r  <= 1'b0;
		end
		else
		begin
			byteCnt_r  <= byteCnt_nxt;
			rxCap_r    <= rxCap_nxt;
			storeEn_r  <= storeEn_nxt;
			overSeen_r <= overSeen_nxt;
			overErr_r  <= overErr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status events and interrupt

	logic [31:0] setVec;
	logic [31:0] clrVec;

	// Events into the sticky status bits
	always_comb
	begin
		setVec              = 32'h00000000;
		setVec[ST_RX_DONE]  = ctrl_r[CTL_RX_RUN] & rxEvt.stored;
		setVec[ST_RX_NULL]  = ctrl_r[CTL_RX_RUN] & (rxPtr_r[DESC_W-1:0] == '0);
		setVec[ST_RX_OVER]  = overErr_nxt;
		setVec[ST_RX_EARLY] = rxEvt.lenTypeValid;
		setVec[ST_TX_NULL]  = ctrl_r[CTL_TX_RUN] & (txPtr_r[DESC_W-1:0] == '0);
		clrVec              = wrClr ? merge(32'h00000000, wrData, wrStrb) : 32'h00000000;
	end

	bdp_event_irq #(
		.IMPL (ST_IMPL)
	) uIrq (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.setVec  (setVec),
		.clrVec  (clrVec),
		.enVec   (irqEn_nxt),
		.status  (status),
		.irq     (irqInt)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read mux

	// Register read data by address; clear register reads zero
	always_comb
	begin
		rdData = 32'h00000000;
		rdOk   = 1'b1;
		if (hit(s_axi_araddr, OFF_CTRL))
			rdData = {30'h00000000, ctrl_r};
		else if (hit(s_axi_araddr, OFF_TX_PTR))
			rdData = txPtr_r;
		else if (hit(s_axi_araddr, OFF_RX_PTR))
			rdData = rxPtr_r;
		else if (hit(s_axi_araddr, OFF_RX_SIZE))
			rdData = {rxCap_r, rxMax_r};
		else if (hit(s_axi_araddr, OFF_STATUS))
			rdData = status;
		else if (hit(s_axi_araddr, OFF_IRQ_EN))
			rdData = irqEn_r;
		else if (!hit(s_axi_araddr, OFF_IRQ_CLR))
			rdOk = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops

	assign descPtr.tx    = txPtr_r[DESC_W-1:0];
	assign descPtr.rx    = rxPtr_r[DESC_W-1:0];
	assign txRun         = ctrl_r[CTL_TX_RUN];
	assign rxRun         = ctrl_r[CTL_RX_RUN];
	assign rxStoreEnable = storeEn_r;
	assign rxOversizeErr = overErr_r;
	assign irq           = irqInt;
endmodule
`default_nettype wire

// File: design/bdp_pkg.sv
`default_nettype none
package bdp_pkg;
	// Bus geometry and responses
	localparam int          BDP_ADDR_W   = 16;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// Register byte offsets
	localparam logic [15:0] OFF_CTRL     = 16'h9000;
	localparam logic [15:0] OFF_TX_PTR   = 16'h9008;
	localparam logic [15:0] OFF_RX_PTR   = 16'h900C;
	localparam logic [15:0] OFF_RX_SIZE  = 16'h9010;
	localparam logic [15:0] OFF_STATUS   = 16'h9014;
	localparam logic [15:0] OFF_IRQ_CLR  = 16'h9018;
	localparam logic [15:0] OFF_IRQ_EN   = 16'h901C;
	// Values after reset
	localparam logic [31:0] PTR_RST      = 32'hFFFFFFFF;
	localparam logic [15:0] MAX_RST      = 16'h0000;
	localparam logic [15:0] CAP_RST      = 16'h0000;
	localparam logic [1:0]  CTRL_RST     = 2'h0;
	localparam logic [31:0] IRQ_EN_RST   = 32'h00000000;
	// Field positions
	localparam int          DESC_W       = 26;
	localparam int          CTL_TX_RUN   = 0;
	localparam int          CTL_RX_RUN   = 1;
	localparam int          MAX_LSB      = 0;
	localparam int          CAP_LSB      = 16;
	localparam int          ST_RX_DONE   = 0;
	localparam int          ST_RX_NULL   = 1;
	localparam int          ST_RX_OVER   = 3;
	localparam int          ST_RX_EARLY  = 5;
	localparam int          ST_TX_NULL   = 17;
	localparam logic [31:0] ST_IMPL      = 32'h0002002B;
	localparam logic [15:0] CNT_MAX      = 16'hFFFF;
	// Transmit side events from the engine
	typedef struct packed {
		logic              done;     // Frame handled
		logic [DESC_W-1:0] nextDesc; // Following descriptor address
	} bdp_tx_evt_t;
	// Receive side events from the engine
	typedef struct packed {
		logic              start;        // First byte of a frame
		logic              byteValid;    // One byte received
		logic              lenTypeValid; // Length/type field complete
		logic [15:0]       lenType;      // Length/type value
		logic              stored;       // Frame stored to memory
		logic [DESC_W-1:0] nextDesc;     // Following descriptor address
	} bdp_rx_evt_t;
	// Pointers handed to the engine
	typedef struct packed {
		logic [DESC_W-1:0] tx; // Current transmit descriptor
		logic [DESC_W-1:0] rx; // Current receive descriptor
	} bdp_ptr_t;
endpackage
`default_nettype wire

// File: design/bdp_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module bdp_axil_slave
	import bdp_pkg::*;
(
	input  wire logic                  mclk,          // System clock
	input  wire logic                  sys_rst,       // Async reset
	input  wire logic [BDP_ADDR_W-1:0] s_axi_awaddr,  // Write address
	input  wire logic                  s_axi_awvalid, // Write address valid
	output logic                       s_axi_awready, // Write address ready
	input  wire logic [31:0]           s_axi_wdata,   // Write data
	input  wire logic [3:0]            s_axi_wstrb,   // Byte enables
	input  wire logic                  s_axi_wvalid,  // Write data valid
	output logic                       s_axi_wready,  // Write data ready
	output logic [1:0]                 s_axi_bresp,   // Write response
	output logic                       s_axi_bvalid,  // Write response valid
	input  wire logic                  s_axi_bready,  // Write response ready
	input  wire logic [BDP_ADDR_W-1:0] s_axi_araddr,  // Read address
	input  wire logic                  s_axi_arvalid, // Read address valid
	output logic                       s_axi_arready, // Read address ready
	output logic [31:0]                s_axi_rdata,   // Read data
	output logic [1:0]                 s_axi_rresp,   // Read response
	output logic                       s_axi_rvalid,  // Read data valid
	input  wire logic                  s_axi_rready,  // Read data ready
	output logic                       wrEn,          // Register write pulse
	output logic [BDP_ADDR_W-1:0]      wrAddr,        // Register write address
	output logic [31:0]                wrData,        // Register write data
	output logic [3:0]                 wrStrb,        // Register byte enables
	input  wire logic                  wrOk,          // Write address mapped
	input  wire logic [31:0]           rdData,        // Data at araddr
	input  wire logic                  rdOk           // Read address mapped
);
	logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
	logic bValid_r, bValid_nxt, rValid_r, rValid_nxt;
	logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
	logic [31:0] rData_r, rData_nxt, wData_r, wData_nxt;
	logic [3:0] wStrb_r, wStrb_nxt;
	logic [BDP_ADDR_W-1:0] awAddr_r, awAddr_nxt;

	assign s_axi_awready = ~awHeld_r;
	assign s_axi_wready  = ~wHeld_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_arready = ~rValid_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rresp   = rResp_r;
	assign s_axi_rdata   = rData_r;
	assign wrAddr        = awAddr_r;
	assign wrData        = wData_r;
	assign wrStrb        = wStrb_r;
	assign wrEn          = awHeld_r & wHeld_r & ~bValid_r;

	// Channel capture, write commit and answers
	always_comb
	begin
		awHeld_nxt = awHeld_r;
		wHeld_nxt  = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt  = wData_r;
		wStrb_nxt  = wStrb_r;
		bValid_nxt = bValid_r & ~s_axi_bready;
		bResp_nxt  = bResp_r;
		rValid_nxt = rValid_r & ~s_axi_rready;
		rResp_nxt  = rResp_r;
		rData_nxt  = rData_r;
		if (s_axi_awvalid & ~awHeld_r)
		begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid & ~wHeld_r)
		begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (wrEn)
		begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
			bValid_nxt = 1'b1;
			bResp_nxt  = wrOk ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_axi_arvalid & ~rValid_r)
		begin
			rValid_nxt = 1'b1;
			rData_nxt  = rdOk ? rdData : 32'h00000000;
			rResp_nxt  = rdOk ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Bus state registers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= '0;
			wData_r  <= 32'h00000000;
			wStrb_r  <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r  <= RESP_OKAY;
			rValid_r <= 1'b0;
			rResp_r  <= RESP_OKAY;
			rData_r  <= 32'h00000000;
		end
		else
		begin
			awHeld_r <= awHeld_nxt;
			wHeld_r  <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r  <= wData_nxt;
			wStrb_r  <= wStrb_nxt;
			bValid_r <= bValid_nxt;
			bResp_r  <= bResp_nxt;
			rValid_r <= rValid_nxt;
			rResp_r  <= rResp_nxt;
			rData_r  <= rData_nxt;
		end
	end
endmodule
`default_nettype wire

// File: design/bdp_event_irq.sv
`timescale 1ns/1ps
`default_nettype none
module bdp_event_irq
	import bdp_pkg::*;
#(
	parameter logic [31:0] IMPL = ST_IMPL // Bits that exist
)(
	input  wire logic        mclk,    // System clock
	input  wire logic        sys_rst, // Async reset
	input  wire logic [31:0] setVec,  // Event pulses
	input  wire logic [31:0] clrVec,  // Clear pulses
	input  wire logic [31:0] enVec,   // Interrupt enables
	output logic [31:0]      status,  // Sticky status
	output logic             irq      // Level interrupt
);
	logic [31:0] stat_r, stat_nxt;
	logic        irq_r, irq_nxt;

	assign status = stat_r;
	assign irq    = irq_r;

	// Sticky bits, a set beats a clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < 32; i++)
		begin : gBit
			assign stat_nxt[i] = IMPL[i] & (setVec[i] | (stat_r[i] & ~clrVec[i]));
		end
	endgenerate

	assign irq_nxt = |(stat_nxt & enVec);

	// Status and interrupt registers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stat_r <= 32'h00000000;
			irq_r  <= 1'b0;
		end
		else
		begin
			stat_r <= stat_nxt;
			irq_r  <= irq_nxt;
		end
	end
endmodule
`default_nettype wire

// File: bench/bdp_desc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bdp_desc_regs_monitor
	import bdp_pkg::*;
(
	input wire logic        mclk,          // Clock
	input wire logic        sys_rst,       // Reset
	input wire logic        s_axi_awvalid, // AW valid
	input wire logic        s_axi_awready, // AW ready
	input wire logic        s_axi_wvalid,  // W valid
	input wire logic        s_axi_wready,  // W ready
	input wire logic        s_axi_bvalid,  // B valid
	input wire logic        s_axi_bready,  // B ready
	input wire logic        s_axi_arvalid, // AR valid
	input wire logic        s_axi_arready, // AR ready
	input wire logic        s_axi_rvalid,  // R valid
	input wire bdp_tx_evt_t txEvt,         // Tx events
	input wire bdp_rx_evt_t rxEvt,         // Rx events
	input wire bdp_ptr_t    descPtr,       // Pointers
	input wire logic        txRun,         // Tx run
	input wire logic        rxRun,         // Rx run
	input wire logic        rxStoreEnable, // Store allowed
	input wire logic        rxOversizeErr  // Oversize pulse
);
	// One clock domain for every check
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	chk_tx_advance: assert property (txEvt.done && txRun |=> descPtr.tx == $past(txEvt.nextDesc))
		else $error("tx pointer missed advance");
	chk_tx_idle_hold: assert property (txEvt.done && !txRun |=> $stable(descPtr.tx) || $rose(s_axi_bvalid))
		else $error("tx pointer moved while halted");
	chk_rx_advance: assert property (rxEvt.stored && rxRun |=> descPtr.rx == $past(rxEvt.nextDesc))
		else $error("rx pointer missed advance");
	chk_ovs_single: assert property (rxOversizeErr |=> !rxOversizeErr)
		else $error("oversize pulse too long");
	chk_ovs_cause: assert property (rxOversizeErr |-> $past(rxEvt.byteValid) && !$past(rxStoreEnable))
		else $error("oversize without excess byte");
	chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
endmodule
bind bdp_desc_regs bdp_desc_regs_monitor u_mon (.*);
`default_nettype wire

// File: bench/bdp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bdp_mem_model
	import bdp_pkg::*;
(
	input  wire logic      mclk,    // Clock
	input  wire logic      sys_rst, // Reset
	input  wire bdp_ptr_t  descPtr, // Current descriptors
	input  wire logic      txGo,    // Handle one tx frame
	input  wire logic      rxGo,    // Receive one frame
	input  wire logic [15:0] rxLen, // Frame bytes, 14 or more
	output var bdp_tx_evt_t txEvt,  // Tx events
	output var bdp_rx_evt_t rxEvt,  // Rx events
	output logic           busy     // Frame in progress
);
	logic [15:0] cnt;
	logic [15:0] len;
	// Frame sequencer; idle fields toggle so stale values never look valid
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt <= 16'h0000;
			len <= 16'h0000;
			txEvt <= '0;
			rxEvt <= '0;
		end
		else
		begin
			txEvt.done <= txGo;
			txEvt.nextDesc <= txGo ? descPtr.tx + 26'h10 : ~txEvt.nextDesc;
			if (rxGo)
				len <= rxLen;
			cnt <= rxGo ? 16'h0001 : (cnt == 16'h0000 || cnt > len) ? 16'h0000 : cnt + 16'h0001;
			rxEvt.byteValid <= cnt != 16'h0000 && cnt <= len;
			rxEvt.start <= cnt == 16'h0001;
			rxEvt.lenTypeValid <= cnt == 16'h000E;
			rxEvt.lenType <= cnt == 16'h000E ? len : ~rxEvt.lenType;
			rxEvt.stored <= cnt != 16'h0000 && cnt == len + 16'h0001;
			// Next start is current start plus frame size
			rxEvt.nextDesc <= cnt == len + 16'h0001 ? descPtr.rx + {10'h000, len} : ~rxEvt.nextDesc;
		end
	end
	assign busy = cnt != 16'h0000 || txEvt.done || rxEvt.stored;
endmodule
`default_nettype wire

// File: bench/bdp_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module buffered_dma_descriptor_pointers_tb_top;
	import bdp_pkg::*;
	typedef struct packed {logic [31:0] d; logic [1:0] r;} bdp_exp_t;
	logic [BDP_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0]            s_axi_awprot, s_axi_arprot;
	logic [31:0]           s_axi_wdata, s_axi_rdata, tp, rp;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic [15:0]           rxLen, lfsr;
	logic mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic txRun, rxRun, rxStoreEnable, rxOversizeErr, irq, txGo, rxGo, busy;
	bdp_tx_evt_t txEvt;
	bdp_rx_evt_t rxEvt;
	bdp_ptr_t    descPtr;
	bdp_exp_t    rq[$], wq[$], be, re;
	int          num_errors, checked, ovCnt;
	bdp_desc_regs dut (.*);
	bdp_mem_model u_mem (.*);
	always #10 mclk = ~mclk;
	////////////////////////////////////////
	task automatic give_verdict;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tmo(input logic ok);
		if (!ok)
		begin
			cmp(32'h0, 32'h1);
			give_verdict();
		end
	endtask
	task automatic rnd(output logic [31:0] v);
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		v = {lfsr, ~lfsr};
	endtask
	// Bus master: write and read, holding each channel until taken
	task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int n;
		wq.push_back('{32'h0, r});
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid && n < 60);
		s_axi_bready <= 1'b0;
		tmo(s_axi_bvalid);
	endtask
	task automatic axr(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		rq.push_back('{e, r});
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid && n < 60);
		s_axi_rready <= 1'b0;
		tmo(s_axi_rvalid);
	endtask
	// One frame through the memory model, then wait for it to finish
	task automatic frame(input logic tx, input logic [15:0] l);
		int n;
		@(posedge mclk);
		txGo <= tx;
		rxGo <= !tx;
		rxLen <= l;
		@(posedge mclk);
		txGo <= 1'b0;
		rxGo <= 1'b0;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (busy && n < 60);
		tmo(!busy);
	endtask
	// Response watcher takes the oldest expectation per answer
	always @(posedge mclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
		begin
			be = wq.pop_front();
			cmp({30'h0, s_axi_bresp}, {30'h0, be.r});
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			re = rq.pop_front();
			cmp(s_axi_rdata, re.d);
			cmp({30'h0, s_axi_rresp}, {30'h0, re.r});
		end
		if (rxOversizeErr === 1'b1) ovCnt++;
	end
	////////////////////////////////////////
	// Main sequence
	initial
	begin
		{mclk, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, txGo, rxGo, rxLen, num_errors, checked, ovCnt} = '0;
		lfsr = 16'd10937;
		sys_rst = 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		axr(OFF_RX_PTR, PTR_RST, RESP_OKAY);
		axr(OFF_TX_PTR, PTR_RST, RESP_OKAY);
		axr(16'h9004, 32'h0, RESP_SLVERR);
		rnd(tp);
		rnd(rp);
		tp = tp | 32'h100;
		rp = rp | 32'h100;
		axw(16'h9020, tp, 4'hF, RESP_SLVERR);
		axw(OFF_TX_PTR, tp, 4'hF, RESP_OKAY);
		axw(OFF_RX_PTR, rp, 4'hF, RESP_OKAY);
		axr(OFF_RX_PTR, rp, RESP_OKAY);
		cmp({6'h0, descPtr.tx}, {6'h0, tp[25:0]});
		cmp({6'h0, descPtr.rx}, {6'h0, rp[25:0]});
		axw(OFF_RX_SIZE, 32'hFFFF0014, 4'hF, RESP_OKAY);
		axr(OFF_RX_SIZE, 32'h00000014, RESP_OKAY);
		axw(OFF_IRQ_EN, 32'h28, 4'hF, RESP_OKAY);
		axw(OFF_CTRL, 32'h3, 4'hF, RESP_OKAY);
		cmp({30'h0, rxRun, txRun}, 32'h3);
		frame(1'b1, 16'h0);
		cmp({6'h0, descPtr.tx}, {6'h0, tp[25:0] + 26'h10});
		frame(1'b0, 16'd18);
		cmp({31'h0, rxStoreEnable}, 32'h1);
		cmp({6'h0, descPtr.rx}, {6'h0, rp[25:0] + 26'd18});
		cmp(ovCnt, 0);
		cmp({31'h0, irq}, 32'h1);
		axr(OFF_STATUS, 32'h21, RESP_OKAY);
		// Halt before reading the captured length
		axw(OFF_CTRL, 32'h0, 4'hF, RESP_OKAY);
		axr(OFF_RX_SIZE, 32'h00120014, RESP_OKAY);
		axw(OFF_IRQ_CLR, 32'h21, 4'hF, RESP_OKAY);
		axr(OFF_STATUS, 32'h0, RESP_OKAY);
		cmp({31'h0, irq}, 32'h0);
		axw(OFF_CTRL, 32'h3, 4'hF, RESP_OKAY);
		frame(1'b0, 16'd24);
		cmp({31'h0, rxStoreEnable}, 32'h0);
		cmp(ovCnt, 1);
		cmp({6'h0, descPtr.rx}, {6'h0, rp[25:0] + 26'd42});
		axr(OFF_STATUS, 32'h29, RESP_OKAY);
		axw(OFF_IRQ_EN, 32'h0, 4'hF, RESP_OKAY);
		cmp({31'h0, irq}, 32'h0);
		axw(OFF_IRQ_CLR, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
		axw(OFF_RX_PTR, 32'h0, 4'hF, RESP_OKAY);
		axr(OFF_STATUS, 32'h2, RESP_OKAY);
		axw(OFF_CTRL, 32'h0, 4'hF, RESP_OKAY);
		frame(1'b1, 16'h0);
		cmp({6'h0, descPtr.tx}, {6'h0, tp[25:0] + 26'h10});
		give_verdict();
	end
endmodule
`default_nettype wire
